// ### hw/ledc_counter.sv
// Low-energy 16-bit down counter with compares, top reload and repeat modes.
//
// Contract
// R1 - Start and stop together: stop wins, counter stays halted.
// R2 - Running status high exactly while the counter counts.
// R3 - Counter is 16-bit with two compares; repeat registers are 8-bit.
// R4 - Counter readable only; clear command forces it to zero.
// R5 - Clear with start clears first, then counts from top value.
// R6 - Counter equal to compare A or B sets matching compare flag.
// R7 - Top option reloads from compare A on underflow, else wraps to ffff.
// R8 - Underflow flag is set when the counter reaches zero; the code sets it on the tick that leaves zero.
// R9 - Buffered top copies compare B into A as repeat A nears zero.
// R10 - Software write to compare A beats buffered top load.
// R11 - Repeat select: 00 free, 01 one-shot, 10 buffered, 11 double.
// R12 - One-shot decrements repeat A per underflow, stops at 1 to 0.
// R13 - Software write to repeat A beats a scheduled decrement.
// R14 - Buffered mode reloads A from B if B fresh and nonzero.
// R15 - B consumed marker set on load into A, cleared by B write.
// R16 - Buffered start with counter and A zero, B nonzero loads B.
// R17 - Double mode decrements both, holds at zero, runs while either set.
// R18 - Double mode write while running gives at least that many underflows.
// R19 - Repeat flags set on decrement to zero; A flag also on B load.
// R20 - Clear overrides updates; following wrap gives no underflow event.
// R21 - External trigger starts the counter like a software start.
// R22 - Counter tick comes from prescaled low-frequency clock outside.
// R23 - Running drops in the same cycle self-stop ceases counting.
`timescale 1ns/1ps
module ledc_counter
  import ledc_pkg::*;
(
  // Clock, reset and enable.
  input wire logic clock,
  input wire logic rst,
  input wire logic clockEnable,
  // Counter tick from the prescaled low-frequency clock, asynchronous.
  input wire logic lowFreqTick,
  // Command pulses, one cycle each.
  input wire logic cmdStart,
  input wire logic cmdStop,
  input wire logic cmdClear,
  input wire logic externalTrigger,
  // Configuration levels.
  input wire logic topFromCompareA,
  input wire logic bufferedTop,
  input wire ledc_pkg::ledc_repeat_type repeatSelect,
  // Register writes.
  input wire logic compareAWrite,
  input wire logic compareBWrite,
  input wire logic repeatAWrite,
  input wire logic repeatBWrite,
  input wire logic [15:0] writeData,
  // Flag clears, one bit per flag: uf, cmpA, cmpB, repA, repB.
  input wire logic [4:0] flagClear,
  // Register contents and status.
  output logic [15:0] countValue,
  output logic [15:0] compareA,
  output logic [15:0] compareB,
  output logic [7:0] repeatA,
  output logic [7:0] repeatB,
  output logic running,
  // Sticky flags: uf, cmpA, cmpB, repA, repB.
  output logic [4:0] flags
);

  ////////////////////////////////////////////////////////////////////////
  // Synchronised tick, sequencer terms and next-state values.
  logic tickMeta;
  logic tickSync;
  logic tickLast;
  logic tick;
  logic skipUnderflow;
  logic repeatBConsumed;
  logic startReq;
  logic startLoadB;
  logic underflow;
  logic [15:0] topValue;
  logic bLoad;
  logic lastRepeatA;
  logic nextRepeatBZero;
  logic decA;
  logic decB;
  logic selfStop;
  logic [15:0] next_count;
  logic next_running;
  logic [7:0] next_repeatA;

  // Two-flop synchroniser for the asynchronous tick level.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tickMeta <= 1'b0;
      tickSync <= 1'b0;
    end else if (clockEnable) begin
      tickMeta <= lowFreqTick;
      tickSync <= tickMeta;
    end
  end

  // Edge detector; it resets to the idle low level, so reset makes no tick.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tickLast <= 1'b0;
    end else if (clockEnable) begin
      tickLast <= tickSync;
    end
  end

  assign tick = tickSync & ~tickLast;

  ////////////////////////////////////////////////////////////////////////
  // Combinational sequencing of counter and repeat registers.
  // Trigger and software start share one path; a stop in the cycle wins.
  assign startReq = (cmdStart | externalTrigger) & ~cmdStop; // R1 R21
  // Top value is compare A when selected, all ones otherwise.
  assign topValue = topFromCompareA ? compareA : CountWrapValue; // R7
  // Underflow is the tick that leaves zero, unless a clear armed the skip.
  assign underflow = running & tick & (countValue == CountZero)
                     & ~skipUnderflow; // R8 R20
  // A buffered start loads repeat A from repeat B.
  assign startLoadB = startReq & ~running & repeatSelect == REP_BUFFERED
                      & countValue == CountZero & repeatA == RepeatZero
                      & repeatB != RepeatZero; // R16
  // Repeat A counts underflows in every mode but free, never below zero.
  assign decA = underflow & (repeatSelect != REP_FREE)
                & (repeatA != RepeatZero);
  assign decB = underflow & (repeatSelect == REP_DOUBLE)
                & (repeatB != RepeatZero); // R17
  // Repeat A is on its last count and would reach zero on this underflow.
  assign lastRepeatA = decA & (repeatA == RepeatOne);
  // A write to repeat A discards the load and leaves repeat B unused.
  assign bLoad = ((lastRepeatA & repeatSelect == REP_BUFFERED
                   & ~repeatBConsumed & repeatB != RepeatZero)
                  | startLoadB) & ~repeatAWrite; // R14 R15
  // Repeat B as it will stand after this edge; a write counts first.
  assign nextRepeatBZero = repeatBWrite ? (writeData[7:0] == RepeatZero)
                           : (repeatB == RepeatZero)
                             | (decB & repeatB == RepeatOne); // R18

  // Write beats buffer load, which beats the decrement.
  always_comb begin
    next_repeatA = repeatA;
    if (repeatAWrite) begin
      next_repeatA = writeData[7:0]; // R13
    end else if (bLoad) begin
      next_repeatA = repeatB; // R14
    end else if (decA) begin
      next_repeatA = repeatA - RepeatOne; // R12
    end
  end

  // Self-stop per repeat mode; free mode stops only on command.
  always_comb begin
    selfStop = 1'b0;
    unique case (repeatSelect) // R11
      REP_FREE: selfStop = 1'b0;
      REP_ONESHOT: selfStop = decA & next_repeatA == RepeatZero; // R12
      REP_BUFFERED: selfStop = decA & next_repeatA == RepeatZero;
      REP_DOUBLE: selfStop = underflow & (next_repeatA == RepeatZero)
        & nextRepeatBZero; // R17 R18
    endcase
  end

  // Stop beats start, and a start in the last cycle keeps it running.
  always_comb begin
    next_running = running;
    if (cmdStop) begin
      next_running = 1'b0; // R1
    end else if (startReq) begin
      next_running = 1'b1; // R21
    end else if (selfStop) begin
      next_running = 1'b0; // R23
    end
  end

  // Clear beats the count; from zero the counter reloads the top value.
  always_comb begin
    next_count = countValue;
    if (cmdClear) begin
      next_count = CountZero; // R4 R5 R20
    end else if (running & tick) begin
      next_count = (countValue == CountZero) ? topValue
                   : countValue - 16'h0001; // R7
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter, running status and clear bookkeeping.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      countValue <= CountZero;
    end else if (clockEnable) begin
      countValue <= next_count; // R3 R4
    end
  end

  // Running status drops in the very cycle that counting ceases.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      running <= 1'b0;
    end else if (clockEnable) begin
      running <= next_running; // R2
    end
  end

  // A clear arms a one-time skip so the wrap back to top is no underflow.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      skipUnderflow <= 1'b0;
    end else if (clockEnable) begin
      if (cmdClear) begin
        skipUnderflow <= 1'b1; // R20
      end else if (running & tick) begin
        skipUnderflow <= 1'b0;
      end
    end
  end

  // Repeat registers and the consumed marker of repeat B.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      repeatA <= RepeatZero;
    end else if (clockEnable) begin
      repeatA <= next_repeatA;
    end
  end

  // Repeat B: a software write beats the double-mode decrement.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      repeatB <= RepeatZero;
    end else if (clockEnable) begin
      if (repeatBWrite) begin
        repeatB <= writeData[7:0];
      end else if (decB) begin
        repeatB <= repeatB - RepeatOne; // R17
      end
    end
  end

  // Consumed marker: each written repeat B value is auto-reloaded only once; a buffered start ignores the marker.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      repeatBConsumed <= 1'b0;
    end else if (clockEnable) begin
      if (repeatBWrite) begin
        repeatBConsumed <= 1'b0; // R15
      end else if (bLoad) begin
        repeatBConsumed <= 1'b1; // R15
      end
    end
  end

  // Compare registers with buffered top load.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      compareA <= CountZero;
    end else if (clockEnable) begin
      if (compareAWrite) begin
        compareA <= writeData; // R10
      end else if (bufferedTop & lastRepeatA) begin
        compareA <= compareB; // R9
      end
    end
  end

  // Compare B changes only by software write.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      compareB <= CountZero;
    end else if (clockEnable) begin
      if (compareBWrite) begin
        compareB <= writeData;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky flags; a set in the clearing cycle wins.
  logic [4:0] flagSet;
  logic matchA;
  logic matchB;
  // Compare flags fire on the step onto the value, not while parked on it.
  assign matchA = running & tick & (next_count == compareA)
                  & (countValue != compareA); // R6
  assign matchB = running & tick & (next_count == compareB)
                  & (countValue != compareB); // R6
  // A repeat flag needs a real decrement to zero, or for A a load from B; a write suppresses it.
  assign flagSet = {
    decB & (repeatB == RepeatOne) & ~repeatBWrite,
    (lastRepeatA & ~repeatAWrite) | bLoad, // R19
    matchB,
    matchA,
    underflow // R8
  };

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flags <= 5'h00;
    end else if (clockEnable) begin
      flags <= (flags & ~flagClear) | flagSet;
    end
  end

endmodule

// ### hw/ledc_pkg.sv
// Package with constants for the low-energy down counter with repeat.
package ledc_pkg;
  localparam int CountWidth = 16;
  localparam int RepeatWidth = 8;
  localparam logic [15:0] CountWrapValue = 16'hffff;
  localparam logic [15:0] CountZero = 16'h0000;
  localparam logic [7:0] RepeatZero = 8'h00;
  localparam logic [7:0] RepeatOne = 8'h01;
  typedef enum logic [1:0] {
    REP_FREE = 2'h0,
    REP_ONESHOT = 2'h1,
    REP_BUFFERED = 2'h2,
    REP_DOUBLE = 2'h3
  } ledc_repeat_type;
endpackage

// ### tb/ledc_counter_assertions.sv
// Assertion checker for the low-energy down counter.
`timescale 1ns/1ps
module ledc_check
  import ledc_pkg::*;
(
  // Clock, reset and inputs.
  input wire logic clock,
  input wire logic rst,
  input wire logic clockEnable,
  input wire logic cmdStop,
  input wire logic cmdClear,
  input wire logic topFromCompareA,
  input wire ledc_pkg::ledc_repeat_type repeatSelect,
  input wire logic repeatAWrite,
  // Outputs.
  input wire logic [15:0] countValue,
  input wire logic [15:0] compareA,
  input wire logic [15:0] compareB,
  input wire logic [7:0] repeatA,
  input wire logic running,
  input wire logic [4:0] flags
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_stop; cmdStop && clockEnable |=> !running; endproperty
  a_stop: assert property (p_stop) else $error("ran after stop");
  property p_clr; cmdClear && clockEnable |=> countValue == CountZero;
  endproperty
  a_clr: assert property (p_clr) else $error("clear missed");
  property p_idle; !running ##1 !running |-> $stable(countValue) ||
    $past(cmdClear); endproperty
  a_idle: assert property (p_idle) else $error("count while idle");
  property p_uf; $rose(flags[0]) |-> $past(countValue) == CountZero;
  endproperty
  a_uf: assert property (p_uf) else $error("underflow flag early");
  property p_top; $past(countValue) == CountZero && countValue != CountZero
    && $stable(compareA) |-> countValue ==
    ($past(topFromCompareA) ? compareA : CountWrapValue); endproperty
  a_top: assert property (p_top) else $error("bad reload");
  property p_cmp; running && $changed(countValue) && !$past(cmdClear) &&
    countValue == compareB |-> ##[0:1] flags[2]; endproperty
  a_cmp: assert property (p_cmp) else $error("compare flag missed");
  property p_one; (running && repeatSelect == REP_ONESHOT && !repeatAWrite
    && repeatA == RepeatOne) ##1 repeatA == RepeatZero |-> !running;
  endproperty
  a_one: assert property (p_one) else $error("no stop");
  property p_rep; $past(repeatA) == RepeatOne && repeatA == RepeatZero &&
    !$past(repeatAWrite) |-> flags[3]; endproperty
  a_rep: assert property (p_rep) else $error("repeat flag missed");
endmodule

// ### tb/testbench.sv
// Self-checking bench for the low-energy down counter.
`timescale 1ns/1ps
module testbench;
  import ledc_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic lowFreqTick = 1'b0;
  logic topFromCompareA = 1'b0;
  logic bufferedTop = 1'b0;
  logic clockEnable = 1'b1;
  logic [3:0] cmd = 4'h0;
  logic [3:0] wr = 4'h0;
  ledc_repeat_type repeatSelect = REP_FREE;
  logic [15:0] writeData = 16'h0000;
  logic [4:0] flagClear = 5'h00;
  logic [15:0] countValue, compareA, compareB;
  logic [7:0] repeatA, repeatB;
  logic running;
  logic [4:0] flags;
  int num_errors = 0;
  int samples_checked = 0;
  ledc_counter DUT (.clock, .rst, .clockEnable, .lowFreqTick,
    .cmdStart(cmd[3]), .cmdStop(cmd[2]), .cmdClear(cmd[1]),
    .externalTrigger(cmd[0]), .topFromCompareA, .bufferedTop,
    .repeatSelect, .compareAWrite(wr[3]), .compareBWrite(wr[2]),
    .repeatAWrite(wr[1]), .repeatBWrite(wr[0]), .writeData, .flagClear,
    .countValue, .compareA, .compareB, .repeatA, .repeatB, .running, .flags);
  always #4 clock = ~clock;
  task automatic check(input logic [15:0] got, exp);
    #1;
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Commands and writes last one cycle; an empty call clears all flags.
  task automatic act(input logic [3:0] c, w, input logic [15:0] d);
    @(posedge clock);
    cmd <= c;
    wr <= w;
    writeData <= d;
    flagClear <= {5{c == 4'h0 && w == 4'h0}};
    @(posedge clock);
    cmd <= 4'h0;
    wr <= 4'h0;
    flagClear <= 5'h00;
    @(posedge clock);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clock);
      lowFreqTick <= 1'b1;
      repeat (3) @(posedge clock);
      lowFreqTick <= 1'b0;
      repeat (3) @(posedge clock);
    end
  endtask
  task automatic test_free();
    act(4'ha, 4'h0, 16'h0000);
    check(countValue, CountZero);
    check(16'(running), 16'h0001);
    tick(1);
    check(countValue, CountWrapValue);
    check(16'(flags[0]), 16'h0000);
    clockEnable <= 1'b0;
    tick(1);
    check(countValue, CountWrapValue);
    clockEnable <= 1'b1;
    act(4'hc, 4'h0, 16'h0000);
    check(16'(running), 16'h0000);
    tick(1);
    check(countValue, CountWrapValue);
    $display("free done");
  endtask
  task automatic test_oneshot();
    topFromCompareA <= 1'b1;
    repeatSelect <= REP_ONESHOT;
    act(4'h0, 4'h8, 16'h0003);
    act(4'h0, 4'h4, 16'h0001);
    act(4'h0, 4'h2, 16'h0002);
    act(4'h0, 4'h0, 16'h0000);
    act(4'ha, 4'h0, 16'h0000);
    tick(5);
    check(16'(repeatA), 16'h0001);
    tick(4);
    check(countValue, 16'h0003);
    check(16'(running), 16'h0000);
    check(16'(flags), 16'h000f);
    $display("oneshot done");
  endtask
  task automatic test_double();
    repeatSelect <= REP_DOUBLE;
    act(4'h0, 4'h2, 16'h0001);
    act(4'h0, 4'h1, 16'h0002);
    act(4'h0, 4'h0, 16'h0000);
    act(4'h1, 4'h0, 16'h0000);
    tick(4);
    check(16'(repeatB), 16'h0001);
    check(16'(running), 16'h0001);
    tick(4);
    check(16'(running), 16'h0000);
    check(16'(flags[4:3]), 16'h0003);
    repeatSelect <= REP_BUFFERED;
    act(4'h2, 4'h1, 16'h0004);
    act(4'h8, 4'h0, 16'h0000);
    check(16'(repeatA), 16'h0004);
    act(4'h4, 4'h0, 16'h0000);
    $display("double and buffered done");
  endtask
  task automatic test_buffered();
    bufferedTop <= 1'b1;
    act(4'h0, 4'h4, 16'h0002);
    act(4'h0, 4'h2, 16'h0001);
    act(4'h0, 4'h1, 16'h0002);
    act(4'h0, 4'h0, 16'h0000);
    act(4'h8, 4'h0, 16'h0000);
    tick(5);
    check(16'(repeatA), 16'h0002);
    check(compareA, 16'h0002);
    check(16'(flags[3]), 16'h0001);
    tick(6);
    fork
      tick(1);
      begin
        repeat (2) @(posedge clock);
        act(4'h0, 4'ha, 16'h0005);
      end
    join
    check(compareA, 16'h0005);
    check(16'(repeatA), 16'h0005);
    check(16'(running), 16'h0001);
    act(4'h4, 4'h0, 16'h0000);
    $display("buffered top done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    test_free();
    test_oneshot();
    test_double();
    test_buffered();
    complete_run();
  end
  initial begin
    repeat (4000) @(posedge clock);
    num_errors++;
    complete_run();
  end
endmodule
bind ledc_counter ledc_check chk (.clock, .rst, .clockEnable, .cmdStop,
  .cmdClear, .topFromCompareA, .repeatSelect, .repeatAWrite, .countValue,
  .compareA, .compareB, .repeatA, .running, .flags);
